// File: common/ovcr_pkg.sv
// Package for the output voltage configuration register bank.
// Assumes a plain register port with 8-bit data on a single 20 MHz clock.
package ovcr_pkg;
   localparam int          ADDR_W           = 4;
   localparam int          DATA_W           = 8;
   localparam logic [3:0]  BUCK_CTRL_ADDR   = 4'h6;
   localparam logic [3:0]  AUX_CTRL_ADDR    = 4'h7;
   localparam logic [3:0]  PB_CTRL_ADDR     = 4'h8;
   localparam logic [7:0]  BUCK_CTRL_RESET  = 8'hAA;
   localparam logic [7:0]  AUX_CTRL_RESET   = 8'h28;
   localparam logic [7:0]  PB_CTRL_RESET    = 8'h08;
   localparam int          BUCK_EN_BIT      = 7;
   localparam int          BUCK_SEL_HI      = 6;
   localparam int          BUCK_SEL_LO      = 5;
   localparam int          BUCK_CODE_HI     = 4;
   localparam int          BUCK_CODE_LO     = 1;
   localparam int          AUX_EN_BIT       = 7;
   localparam int          AUX_CODE_HI      = 6;
   localparam int          AUX_CODE_LO      = 2;
   localparam int          AUX_QUAL_BIT     = 0;
   localparam int          PB_HOLD_HI       = 4;
   localparam int          PB_HOLD_LO       = 3;
   localparam logic [7:0]  BUCK_CTRL_MASK   = 8'hFE;
   localparam logic [7:0]  AUX_CTRL_MASK    = 8'hFD;
   localparam logic [7:0]  PB_CTRL_MASK     = 8'h18;
   localparam logic [1:0]  SEL_LOW_TABLE    = 2'h0;
   localparam logic [1:0]  SEL_LINEAR_13    = 2'h1;
   localparam logic [1:0]  SEL_MID_TABLE    = 2'h2;
   localparam logic [1:0]  SEL_LINEAR_18    = 2'h3;
   localparam logic [11:0] BUCK_BASE_13_MV  = 12'h514;
   localparam logic [11:0] BUCK_BASE_18_MV  = 12'h708;
   localparam logic [11:0] AUX_BASE_MV      = 12'h320;
   localparam logic [11:0] STEP_MV          = 12'h064;
   localparam logic [11:0] AUX_MAX_MV       = 12'hCE4;
   localparam int          CLK_HZ           = 20_000_000;
   localparam int          HOLD_S_0         = 5;
   localparam int          HOLD_S_1         = 9;
   localparam int          HOLD_S_2         = 11;
   localparam int          HOLD_S_3         = 15;
   localparam longint      HOLD_CYC_0       = longint'(HOLD_S_0) * CLK_HZ;
   localparam longint      HOLD_CYC_1       = longint'(HOLD_S_1) * CLK_HZ;
   localparam longint      HOLD_CYC_2       = longint'(HOLD_S_2) * CLK_HZ;
   localparam longint      HOLD_CYC_3       = longint'(HOLD_S_3) * CLK_HZ;
endpackage : ovcr_pkg

// File: logic/ovcr_output_regs.sv
// Register bank for the buck output and the auxiliary regulator output.
// Assumes a one-cycle strobe register port; pins arrive asynchronously.
// What this block does
// - Buck enable bit on drives converter; off disables it and pulls output low.
// - Two-bit buck range select picks one of four voltage ranges.
// - In linear ranges, level code bits 4..1 weigh 800, 400, 200, 100 mV.
// - Range 01 target is 1.30 V plus code times 100 mV.
// - Range 11 target is 1.80 V plus code times 100 mV.
// - Ranges 00 and 10 map each code through a fixed voltage table.
// - Auxiliary enable bit turns aux output on; resets to 0.
// - Aux target is 0.8 V plus five-bit code times 100 mV.
// - Aux code above 3.3 V selects pass-through instead of regulation.
// - Aux level code changes only while enable bit and control pin both disable.
// - Qualifier 0 resets on hold time; 1 also needs valid input supply.
// - Two-bit field selects hold time of 5, 9, 11 or 15 seconds.
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/1ps
module ovcr_output_regs #(
   parameter longint HOLD_0 = ovcr_pkg::HOLD_CYC_0,
   parameter longint HOLD_1 = ovcr_pkg::HOLD_CYC_1,
   parameter longint HOLD_2 = ovcr_pkg::HOLD_CYC_2,
   parameter longint HOLD_3 = ovcr_pkg::HOLD_CYC_3
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [3:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [7:0]  reg_rdata,
   input  wire logic        aux_control_pin,
   input  wire logic        pushbutton_input_n,
   input  wire logic        vin_valid,
   output logic             buck_converter_en,
   output logic             buck_pulldown_en,
   output logic      [11:0] buck_target_mv,
   output logic             aux_regulator_output_en,
   output logic      [11:0] aux_target_mv,
   output logic             aux_passthrough,
   output logic             pushbutton_reset
);
   logic [7:0]  buck_q;
   logic [7:0]  aux_q;
   logic [7:0]  pb_q;
   logic [2:0]  pin_sync_q;
   logic [2:0]  pb_sync_q;
   logic [2:0]  vin_sync_q;
   logic        pin_q;
   logic        pb_q_level;
   logic        vin_q;
   logic [33:0] hold_cnt_q;
   logic [33:0] hold_lim;
   logic [11:0] buck_mv_d;
   logic [11:0] aux_mv_d;
   logic        aux_lock;
   logic        pb_fire_d;

   // Nonlinear ranges, in millivolts, indexed by level code.
   function automatic logic [11:0] table_mv(input logic sel_hi, input logic [3:0] code);
      logic [11:0] lo [16];
      logic [11:0] mid [16];
      lo  = '{12'h44C, 12'h4B0, 12'h4E2, 12'h535, 12'h589, 12'h5DC, 12'h62F, 12'h683,
              12'h6D6, 12'h729, 12'h77D, 12'h7D0, 12'h823, 12'h877, 12'h8CA, 12'h91D};
      mid = '{12'h5DC, 12'h62F, 12'h683, 12'h6D6, 12'h729, 12'h77D, 12'h7D0, 12'h823,
              12'h877, 12'h8CA, 12'h91D, 12'h971, 12'h9C4, 12'hA17, 12'hA6B, 12'hABE};
      return sel_hi ? mid[code] : lo[code];
   endfunction : table_mv

   function automatic logic [11:0] steps_mv(input logic [4:0] code);
      return 12'(code * ovcr_pkg::STEP_MV);
   endfunction : steps_mv

   // Slow pins pass three flops; a change is taken when the last two agree.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_sync_q <= 3'h0;
         pb_sync_q  <= 3'h7;
         vin_sync_q <= 3'h0;
         pin_q      <= 1'b0;
         pb_q_level <= 1'b1;
         vin_q      <= 1'b0;
      end else begin
         pin_sync_q <= {pin_sync_q[1:0], aux_control_pin};
         pb_sync_q  <= {pb_sync_q[1:0], pushbutton_input_n};
         vin_sync_q <= {vin_sync_q[1:0], vin_valid};
         if (pin_sync_q[2] == pin_sync_q[1]) pin_q <= pin_sync_q[2];
         if (pb_sync_q[2] == pb_sync_q[1]) pb_q_level <= pb_sync_q[2];
         if (vin_sync_q[2] == vin_sync_q[1]) vin_q <= vin_sync_q[2];
      end
   end

   // The output counts as disabled only when neither the bit nor the pin enables it.
   assign aux_lock = aux_q[ovcr_pkg::AUX_EN_BIT] | pin_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         buck_q <= ovcr_pkg::BUCK_CTRL_RESET;
      end else if (reg_wr && reg_addr == ovcr_pkg::BUCK_CTRL_ADDR) begin
         buck_q <= reg_wdata & ovcr_pkg::BUCK_CTRL_MASK;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         aux_q <= ovcr_pkg::AUX_CTRL_RESET;
      end else if (reg_wr && reg_addr == ovcr_pkg::AUX_CTRL_ADDR) begin
         aux_q[ovcr_pkg::AUX_EN_BIT]   <= reg_wdata[ovcr_pkg::AUX_EN_BIT];
         aux_q[ovcr_pkg::AUX_QUAL_BIT] <= reg_wdata[ovcr_pkg::AUX_QUAL_BIT];
         if (!aux_lock) begin
            aux_q[ovcr_pkg::AUX_CODE_HI:ovcr_pkg::AUX_CODE_LO] <=
               reg_wdata[ovcr_pkg::AUX_CODE_HI:ovcr_pkg::AUX_CODE_LO];
         end
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pb_q <= ovcr_pkg::PB_CTRL_RESET;
      end else if (reg_wr && reg_addr == ovcr_pkg::PB_CTRL_ADDR) begin
         pb_q <= reg_wdata & ovcr_pkg::PB_CTRL_MASK;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            ovcr_pkg::BUCK_CTRL_ADDR: reg_rdata <= buck_q;
            ovcr_pkg::AUX_CTRL_ADDR:  reg_rdata <= aux_q;
            ovcr_pkg::PB_CTRL_ADDR:   reg_rdata <= pb_q;
            default:                  reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   always_comb begin
      buck_mv_d = 12'h000;
      case (buck_q[ovcr_pkg::BUCK_SEL_HI:ovcr_pkg::BUCK_SEL_LO])
         ovcr_pkg::SEL_LINEAR_13: buck_mv_d = ovcr_pkg::BUCK_BASE_13_MV +
            steps_mv({1'b0, buck_q[ovcr_pkg::BUCK_CODE_HI:ovcr_pkg::BUCK_CODE_LO]});
         ovcr_pkg::SEL_LINEAR_18: buck_mv_d = ovcr_pkg::BUCK_BASE_18_MV +
            steps_mv({1'b0, buck_q[ovcr_pkg::BUCK_CODE_HI:ovcr_pkg::BUCK_CODE_LO]});
         default: buck_mv_d = table_mv(buck_q[ovcr_pkg::BUCK_SEL_HI],
            buck_q[ovcr_pkg::BUCK_CODE_HI:ovcr_pkg::BUCK_CODE_LO]);
      endcase
   end

   assign aux_mv_d = ovcr_pkg::AUX_BASE_MV +
                     steps_mv(aux_q[ovcr_pkg::AUX_CODE_HI:ovcr_pkg::AUX_CODE_LO]);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         buck_converter_en       <= 1'b0;
         buck_pulldown_en        <= 1'b0;
         buck_target_mv          <= 12'h000;
         aux_regulator_output_en <= 1'b0;
         aux_target_mv           <= 12'h000;
         aux_passthrough         <= 1'b0;
      end else begin
         buck_converter_en       <= buck_q[ovcr_pkg::BUCK_EN_BIT];
         buck_pulldown_en        <= ~buck_q[ovcr_pkg::BUCK_EN_BIT];
         buck_target_mv          <= buck_mv_d;
         aux_regulator_output_en <= aux_q[ovcr_pkg::AUX_EN_BIT];
         aux_target_mv           <= aux_mv_d;
         aux_passthrough         <= aux_mv_d > ovcr_pkg::AUX_MAX_MV;
      end
   end

   always_comb begin
      case (pb_q[ovcr_pkg::PB_HOLD_HI:ovcr_pkg::PB_HOLD_LO])
         2'h0:    hold_lim = 34'(HOLD_0);
         2'h1:    hold_lim = 34'(HOLD_1);
         2'h2:    hold_lim = 34'(HOLD_2);
         default: hold_lim = 34'(HOLD_3);
      endcase
   end

   // The counter saturates so a held button issues one reset, not a train of them.
   assign pb_fire_d = !pb_q_level && (hold_cnt_q + 34'h1 == hold_lim) &&
                      (!aux_q[ovcr_pkg::AUX_QUAL_BIT] || vin_q);

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hold_cnt_q       <= 34'h0;
         pushbutton_reset <= 1'b0;
      end else begin
         if (pb_q_level) hold_cnt_q <= 34'h0;
         else if (hold_cnt_q < hold_lim) hold_cnt_q <= hold_cnt_q + 34'h1;
         pushbutton_reset <= pb_fire_d;
      end
   end

   property p_buck_pull;
      @(posedge clk) disable iff (!rst_n) 1'b1 |=> buck_pulldown_en == ~buck_converter_en;
   endproperty
   a_buck_pull: assert property (p_buck_pull) else $error("buck pulldown wrong");
   property p_buck_lin;
      @(posedge clk) disable iff (!rst_n)
      buck_q[6:5] == 2'h3 |=> buck_target_mv == 12'h708 + 12'(($past(buck_q[4:1])) * 100);
   endproperty
   a_buck_lin: assert property (p_buck_lin) else $error("range 11 target wrong");
   property p_buck_13;
      @(posedge clk) disable iff (!rst_n)
      buck_q[6:5] == 2'h1 |=> buck_target_mv == 12'h514 + 12'(($past(buck_q[4:1])) * 100);
   endproperty
   a_buck_13: assert property (p_buck_13) else $error("range 01 target wrong");
   property p_buck_tab;
      @(posedge clk) disable iff (!rst_n)
      buck_q[6:1] == 6'h0F |=> buck_target_mv == 12'h91D;
   endproperty
   a_buck_tab: assert property (p_buck_tab) else $error("table top wrong");
   property p_aux_en;
      @(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == 4'h7 |=> ##1 aux_regulator_output_en == $past(reg_wdata[7], 2);
   endproperty
   a_aux_en: assert property (p_aux_en) else $error("aux enable not applied");
   property p_aux_lock;
      @(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == 4'h7 && aux_lock |=> $stable(aux_q[6:2]);
   endproperty
   a_aux_lock: assert property (p_aux_lock) else $error("locked code changed");
   property p_aux_pass;
      @(posedge clk) disable iff (!rst_n) aux_target_mv > 12'hCE4 |-> aux_passthrough;
   endproperty
   a_aux_pass: assert property (p_aux_pass) else $error("pass-through missing");
   property p_pb_qual;
      @(posedge clk) disable iff (!rst_n)
      $rose(pushbutton_reset) |-> $past(!aux_q[0] || vin_q);
   endproperty
   a_pb_qual: assert property (p_pb_qual) else $error("reset without supply");
   property p_rd_zero;
      @(posedge clk) disable iff (!rst_n) reg_rd && reg_addr == 4'h7 |=> reg_rdata[1] == 1'b0;
   endproperty
   a_rd_zero: assert property (p_rd_zero) else $error("unused bit not zero");

   // A cleared enable bit must both stop the converter and pull the output low.
   property p_buck_off;
      @(posedge clk) disable iff (!rst_n)
      !buck_q[ovcr_pkg::BUCK_EN_BIT] |=> buck_pulldown_en && !buck_converter_en;
   endproperty
   a_buck_off: assert property (p_buck_off) else $error("buck not pulled low");

   // A buck write stores every defined field and drops the unused bit.
   property p_wr_buck;
      @(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == ovcr_pkg::BUCK_CTRL_ADDR |=>
         buck_q == ($past(reg_wdata) & ovcr_pkg::BUCK_CTRL_MASK);
   endproperty
   a_wr_buck: assert property (p_wr_buck) else $error("buck write not stored");

   // The mid table tops out below the linear ranges, so a mix-up shows here.
   property p_buck_mid_top;
      @(posedge clk) disable iff (!rst_n)
      buck_q[ovcr_pkg::BUCK_SEL_HI:ovcr_pkg::BUCK_CODE_LO] == 6'h2F |=>
         buck_target_mv == 12'hABE;
   endproperty
   a_buck_mid_top: assert property (p_buck_mid_top) else $error("mid table top wrong");

   // The aux target follows the stored code with a fixed offset and step.
   property p_aux_tgt;
      @(posedge clk) disable iff (!rst_n)
      1'b1 |=> aux_target_mv == ovcr_pkg::AUX_BASE_MV +
         12'($past(aux_q[ovcr_pkg::AUX_CODE_HI:ovcr_pkg::AUX_CODE_LO])) * ovcr_pkg::STEP_MV;
   endproperty
   a_aux_tgt: assert property (p_aux_tgt) else $error("aux target wrong");

   // With the output fully disabled, a written code must be taken as given.
   property p_aux_unlock;
      @(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == ovcr_pkg::AUX_CTRL_ADDR && !aux_lock |=>
         aux_q[ovcr_pkg::AUX_CODE_HI:ovcr_pkg::AUX_CODE_LO] ==
         $past(reg_wdata[ovcr_pkg::AUX_CODE_HI:ovcr_pkg::AUX_CODE_LO]);
   endproperty
   a_aux_unlock: assert property (p_aux_unlock) else $error("unlocked code not taken");

   // A reset pulse must last a single cycle, never two cycles in a row.
   property p_pb_once;
      @(posedge clk) disable iff (!rst_n) pushbutton_reset |=> !pushbutton_reset;
   endproperty
   a_pb_once: assert property (p_pb_once) else $error("reset pulse too long");

   // The pulse comes exactly when the count reaches the selected hold time.
   property p_pb_hold;
      @(posedge clk) disable iff (!rst_n) $rose(pushbutton_reset) |-> hold_cnt_q == hold_lim;
   endproperty
   a_pb_hold: assert property (p_pb_hold) else $error("reset before hold time");

   // Read data stand only in the cycle after a read strobe.
   property p_rd_idle;
      @(posedge clk) disable iff (!rst_n) !reg_rd |=> reg_rdata == 8'h00;
   endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside read");

   c_wr_aux: cover property (@(posedge clk) disable iff (!rst_n) reg_wr && reg_addr == 4'h7);
   c_pass: cover property (@(posedge clk) disable iff (!rst_n) aux_passthrough);
   c_pbrst: cover property (@(posedge clk) disable iff (!rst_n) pushbutton_reset);
   c_lock: cover property (@(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == ovcr_pkg::AUX_CTRL_ADDR && aux_lock);
endmodule : ovcr_output_regs

// File: bench/ovcr_output_regs_tb.sv
// Self-checking bench for the output voltage configuration register bank.
// Assumes the design's one-cycle strobe register port and a 20 MHz clock.
`timescale 1ns/1ps
module ovcr_output_regs_tb;
   localparam int  LIMIT = 20000;
   logic        clk;
   logic        rst_n;
   logic [3:0]  reg_addr;
   logic [7:0]  reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [7:0]  reg_rdata;
   logic        aux_control_pin;
   logic        pushbutton_input_n;
   logic        vin_valid;
   logic        buck_converter_en;
   logic        buck_pulldown_en;
   logic [11:0] buck_target_mv;
   logic        aux_regulator_output_en;
   logic [11:0] aux_target_mv;
   logic        aux_passthrough;
   logic        pushbutton_reset;
   int          bad_count = 0;
   int          checked = 0;
   int          cyc = 0;
   // Table ranges share entries: the low range starts at index 0, the mid range at index 5.
   logic [11:0] tbl [0:20] = '{12'h44C, 12'h4B0, 12'h4E2, 12'h535, 12'h589, 12'h5DC, 12'h62F,
      12'h683, 12'h6D6, 12'h729, 12'h77D, 12'h7D0, 12'h823, 12'h877, 12'h8CA, 12'h91D,
      12'h971, 12'h9C4, 12'hA17, 12'hA6B, 12'hABE};

   // Hold counts are shortened so that each press takes tens of cycles, not seconds.
   ovcr_output_regs #(.HOLD_0(20), .HOLD_1(30), .HOLD_2(40), .HOLD_3(50)) ovcr_output_regs_inst (
      .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .aux_control_pin(aux_control_pin),
      .pushbutton_input_n(pushbutton_input_n), .vin_valid(vin_valid),
      .buck_converter_en(buck_converter_en), .buck_pulldown_en(buck_pulldown_en),
      .buck_target_mv(buck_target_mv), .aux_regulator_output_en(aux_regulator_output_en),
      .aux_target_mv(aux_target_mv), .aux_passthrough(aux_passthrough),
      .pushbutton_reset(pushbutton_reset));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         bad_count = bad_count + 1;
         results();
      end
   end

   task automatic results;
      $display("comparisons %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : results

   task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      checked = checked + 1;
      if (g !== e) begin
         bad_count = bad_count + 1;
         $display("MISMATCH %s expected %0h seen %0h", nm, e, g);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
      // Outputs follow the register one cycle after it updates.
      repeat (2) @(posedge clk);
      #1;
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk("read data", {4'h0, e}, {4'h0, reg_rdata});
   endtask : rd

   task automatic pb(input logic [1:0] sel, input logic q, input logic v, input int lim,
                     input logic fire);
      int n;
      int first;
      int pulses;
      first = -1;
      pulses = 0;
      wr(4'h8, {3'h0, sel, 3'h0});
      wr(4'h7, {7'h14, q});
      vin_valid <= v;
      @(posedge clk);
      pushbutton_input_n <= 1'b0;
      for (n = 0; n < lim + 20; n++) begin
         @(posedge clk);
         #1;
         if (pushbutton_reset === 1'b1) begin
            pulses = pulses + 1;
            if (first < 0) first = n;
         end
      end
      pushbutton_input_n <= 1'b1;
      chk("reset pulse count", {11'h0, fire}, 12'(pulses));
      if (fire) chk("hold time window", 12'h1, {11'h0, first >= lim - 2 && first <= lim + 8});
      repeat (8) @(posedge clk);
   endtask : pb

   initial begin
      logic [11:0] e;
      logic [7:0]  d;
      rst_n = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      aux_control_pin = 1'b0;
      pushbutton_input_n = 1'b1;
      vin_valid = 1'b1;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("reset buck target", 12'h708, buck_target_mv);
      chk("reset buck enable", 12'h1, {11'h0, buck_converter_en});
      chk("reset aux enable", 12'h0, {11'h0, aux_regulator_output_en});
      chk("reset aux target", 12'h708, aux_target_mv);
      rd(4'h6, 8'hAA);
      rd(4'h7, 8'h28);
      rd(4'h8, 8'h08);
      rd(4'hF, 8'h00);
      wr(4'hF, 8'hFF);
      rd(4'hF, 8'h00);
      for (int s = 0; s < 4; s++) begin
         for (int c = 0; c < 16; c++) begin
            d = {c[0] ^ s[0], s[1:0], c[3:0], 1'b1};
            if (s == 1) e = 12'h514 + 12'(c) * 12'h064;
            else if (s == 3) e = 12'h708 + 12'(c) * 12'h064;
            else e = tbl[c + (s == 2 ? 5 : 0)];
            wr(4'h6, d);
            chk("buck target", e, buck_target_mv);
            chk("buck enable", {11'h0, d[7]}, {11'h0, buck_converter_en});
            chk("buck pulldown", {11'h0, ~d[7]}, {11'h0, buck_pulldown_en});
            rd(4'h6, d & 8'hFE);
         end
      end
      for (int c = 0; c < 32; c++) begin
         e = 12'h320 + 12'(c) * 12'h064;
         wr(4'h7, {1'b0, c[4:0], 2'h3});
         chk("aux target", e, aux_target_mv);
         chk("aux passthrough", {11'h0, e > 12'hCE4}, {11'h0, aux_passthrough});
         rd(4'h7, {1'b0, c[4:0], 2'h1});
      end
      wr(4'h7, 8'h8C);
      chk("aux code while enabling", 12'h44C, aux_target_mv);
      chk("aux enable on", 12'h1, {11'h0, aux_regulator_output_en});
      wr(4'h7, 8'hD0);
      chk("aux code locked by bit", 12'h44C, aux_target_mv);
      rd(4'h7, 8'h8C);
      wr(4'h7, 8'h50);
      chk("aux code locked while disabling", 12'h44C, aux_target_mv);
      chk("aux enable off", 12'h0, {11'h0, aux_regulator_output_en});
      aux_control_pin <= 1'b1;
      repeat (6) @(posedge clk);
      wr(4'h7, 8'h50);
      chk("aux code locked by pin", 12'h44C, aux_target_mv);
      aux_control_pin <= 1'b0;
      repeat (6) @(posedge clk);
      wr(4'h7, 8'h50);
      chk("aux code unlocked", 12'hAF0, aux_target_mv);
      for (int s = 0; s < 4; s++) pb(s[1:0], 1'b0, 1'b0, 20 + 10 * s, 1'b1);
      pb(2'h0, 1'b1, 1'b0, 20, 1'b0);
      pb(2'h0, 1'b1, 1'b1, 20, 1'b1);
      results();
   end
endmodule : ovcr_output_regs_tb
